// [logic/mfg_interconnect_test_port.sv]
/*
  Manufacturing interconnect test port: decodes the test-load and snapshot
  vendor requests, holds the test registers, overrides the non-USB output
  pins in test mode and returns pin snapshots.
  Assumes a control-request engine that presents one setup word per request,
  host-to-device data bytes as valid strobes and pulls read bytes on demand.
*/
`timescale 1ns/100ps

// Functional notes
// - Test-load is type 40h, request 05h.
// - Value zero restores normal mode; reset default.
// - Value one enters test mode.
// - Value-one load data beyond seven bytes is stalled.
// - Test mode drives outputs from loaded bits.
// - Byte 0 maps power and strobe outputs.
// - Byte 1 selects; bytes 2-3 data bus.
// - Byte 4 general purpose values and enables.
// - Reserved test bits never reach outputs.
// - Snapshot is type C0h, request 06h, anytime.
// - Snapshot longer than eight bytes is stalled.
// - Snapshot byte 0 returns status inputs.
// - Snapshot bytes 1-2 return control outputs.
// - Snapshot bytes 3-5 bus, general purpose.
// - Byte 6 mode and enable; byte 7 ones.
// - Test mode blocks normal output control.
module mfg_interconnect_test_port (
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     sys_rst_i,
  // Setup stage
  input  wire logic                     setup_valid_i,
  input  wire mfg_test_pkg::setup_pkt_t setup_i,
  // Host-to-device data stage
  input  wire logic                     wr_valid_i,
  input  wire logic [7:0]               wr_data_i,
  // Device-to-host data stage
  input  wire logic                     rd_req_i,
  output logic                          rd_valid_o,
  output logic [7:0]                    rd_data_o,
  // Request handshake
  output logic                          claim_o,
  output logic                          stall_o,
  output logic                          test_mode_o,
  // Pins
  input  wire mfg_test_pkg::out_pins_t  norm_pins_i,
  input  wire mfg_test_pkg::in_pins_t   raw_pins_i,
  output mfg_test_pkg::out_pins_t       pins_o,
  output logic                          data_bus_oe_n_o,
  output logic [2:0]                    gpio_oe_n_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_READ
  } stage_t;

  function automatic logic req_match(input mfg_test_pkg::setup_pkt_t pkt,
                                     input logic [7:0]               rtype,
                                     input logic [7:0]               rcode);
    req_match = (pkt.req_type == rtype) && (pkt.request == rcode);
  endfunction : req_match

  localparam int TEST_LAST = mfg_test_pkg::TEST_BYTES - 1;
  localparam int SNAP_LAST = mfg_test_pkg::SNAP_BYTES - 1;

  stage_t                  stage_q;
  logic                    test_mode_q;
  logic [7:0]              test_q [TEST_LAST:0];
  logic [7:0]              snap_q [SNAP_LAST:0];
  logic [15:0]             wr_ptr_q;
  logic [15:0]             wr_cnt_q;
  logic [15:0]             wr_len_q;
  logic [2:0]              rd_ptr_q;
  logic [3:0]              rd_left_q;
  logic                    rd_valid_q;
  logic [7:0]              rd_data_q;
  mfg_test_pkg::out_pins_t pins_q;
  mfg_test_pkg::out_pins_t test_view;
  mfg_test_pkg::in_pins_t  sin;
  logic [7:0]              snap_view [SNAP_LAST:0];

  logic is_load;
  logic is_snap;
  logic load_bad_value;
  logic load_too_long;
  logic snap_too_long;
  logic setup_stall;
  logic wr_take;
  logic wr_overflow;
  logic rd_take;

  // Pins from outside the clock domain
  pin_input_filter #(
    .WIDTH     (mfg_test_pkg::IN_PIN_BITS)
  ) u_in_filter (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .pins_i    (raw_pins_i),
    .pins_o    (sin)
  );

  // Request decode
  assign is_load        = setup_valid_i &&
                          req_match(setup_i, mfg_test_pkg::LOAD_REQ_TYPE,
                                    mfg_test_pkg::LOAD_REQ_CODE);
  assign is_snap        = setup_valid_i &&
                          req_match(setup_i, mfg_test_pkg::SNAP_REQ_TYPE,
                                    mfg_test_pkg::SNAP_REQ_CODE);
  assign load_bad_value = (setup_i.value != mfg_test_pkg::MODE_NORMAL) &&
                          (setup_i.value != mfg_test_pkg::MODE_TEST);
  assign load_too_long  = (setup_i.value == mfg_test_pkg::MODE_TEST) &&
                          (setup_i.length > mfg_test_pkg::LOAD_LEN);
  assign snap_too_long  = setup_i.length > mfg_test_pkg::SNAP_MAX_LEN;
  assign setup_stall    = (is_load && (load_bad_value || load_too_long)) ||
                          (is_snap && snap_too_long);

  // Bytes past the announced length are refused; in the load stage the length is never above seven
  assign wr_take        = (stage_q == ST_LOAD) && wr_valid_i &&
                          (wr_cnt_q < wr_len_q);
  assign wr_overflow    = (stage_q == ST_LOAD) && wr_valid_i &&
                          (wr_cnt_q >= wr_len_q);
  assign rd_take        = (stage_q == ST_READ) && rd_req_i && (rd_left_q != 4'h0);

  assign claim_o        = is_load || is_snap;
  assign stall_o        = setup_stall || wr_overflow;

  // Request stage; a new setup always aborts the old one
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      stage_q <= ST_IDLE;
    else if (setup_valid_i)
    begin
      if (is_load && !setup_stall && setup_i.value == mfg_test_pkg::MODE_TEST)
        stage_q <= ST_LOAD;
      else if (is_snap && !setup_stall)
        stage_q <= ST_READ;
      else
        stage_q <= ST_IDLE;
    end
    else
    begin
      case (stage_q)
        ST_IDLE: stage_q <= ST_IDLE;
        ST_LOAD: stage_q <= ST_LOAD;
        ST_READ:
        begin
          if (rd_take && rd_left_q == 4'h1)
            stage_q <= ST_IDLE;
        end
        default: stage_q <= ST_IDLE;
      endcase
    end
  end

  // Mode flag
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      test_mode_q <= 1'b0;
    else if (is_load && !setup_stall)
    begin
      if (setup_i.value == mfg_test_pkg::MODE_TEST)
        test_mode_q <= 1'b1;
      else
        test_mode_q <= 1'b0;
    end
  end

  assign test_mode_o = test_mode_q;

  // Load byte pointer and count
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_q <= 16'h0000;
      wr_cnt_q <= 16'h0000;
      wr_len_q <= 16'h0000;
    end
    else if (is_load && !setup_stall)
    begin
      wr_ptr_q <= setup_i.index;
      wr_cnt_q <= 16'h0000;
      wr_len_q <= setup_i.length;
    end
    else if (wr_take)
    begin
      wr_ptr_q <= wr_ptr_q + 16'h0001;
      wr_cnt_q <= wr_cnt_q + 16'h0001;
    end
  end

  // Test registers; positions past the last register are dropped
  genvar t;
  generate
    for (t = 0; t <= TEST_LAST; t++)
    begin : g_test
      always_ff @(posedge sys_clk_i)
      begin
        if (sys_rst_i)
          test_q[t] <= mfg_test_pkg::TEST_RESET;
        else if (wr_take && wr_ptr_q == 16'(t))
          test_q[t] <= wr_data_i;
      end
    end
  endgenerate

  // Output view built from the test registers
  always_comb
  begin
    test_view                        = '0;
    test_view.low_power_indicator    =
      test_q[mfg_test_pkg::OFS_CTRL_A][mfg_test_pkg::B0_LOW_POWER];
    test_view.high_current_request_n =
      test_q[mfg_test_pkg::OFS_CTRL_A][mfg_test_pkg::B0_HIGH_CUR];
    test_view.drive_reset_n          =
      test_q[mfg_test_pkg::OFS_CTRL_A][mfg_test_pkg::B0_RESET];
    test_view.drive_write_strobe_n   =
      test_q[mfg_test_pkg::OFS_CTRL_A][mfg_test_pkg::B0_WRITE];
    test_view.drive_read_strobe_n    =
      test_q[mfg_test_pkg::OFS_CTRL_A][mfg_test_pkg::B0_READ];
    test_view.drive_dma_ack_n        =
      test_q[mfg_test_pkg::OFS_CTRL_A][mfg_test_pkg::B0_DMA_ACK];
    test_view.drive_pullup_enable    =
      test_q[mfg_test_pkg::OFS_CTRL_A][mfg_test_pkg::B0_PULLUP];
    test_view.drive_chip_select_n    =
      test_q[mfg_test_pkg::OFS_CTRL_B][mfg_test_pkg::B1_CS_LSB +: 2];
    test_view.drive_reg_address      =
      test_q[mfg_test_pkg::OFS_CTRL_B][mfg_test_pkg::B1_ADDR_LSB +: 3];
    test_view.serial_clock           =
      test_q[mfg_test_pkg::OFS_CTRL_B][mfg_test_pkg::B1_SCLK];
    test_view.data_bus_output_enable =
      test_q[mfg_test_pkg::OFS_CTRL_B][mfg_test_pkg::B1_BUS_EN];
    test_view.drive_data_bus         = {test_q[mfg_test_pkg::OFS_BUS_HIGH],
                                        test_q[mfg_test_pkg::OFS_BUS_LOW]};
    test_view.gpio_out               =
      test_q[mfg_test_pkg::OFS_GP_CTRL][mfg_test_pkg::B4_GP_LSB +: 3];
    test_view.gpio_enable            =
      test_q[mfg_test_pkg::OFS_GP_CTRL][mfg_test_pkg::B4_GP_EN_LSB +: 3];
    // Reserved bits and the spare byte are simply never read
  end

  // Output register: test mode fully replaces normal control
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      pins_q <= '0;
    else if (test_mode_q)
      pins_q <= test_view;
    else
      pins_q <= norm_pins_i;
  end

  assign pins_o          = pins_q;
  assign data_bus_oe_n_o = ~pins_q.data_bus_output_enable;
  assign gpio_oe_n_o     = ~pins_q.gpio_enable;

  // Snapshot assembly from filtered inputs and current output states
  always_comb
  begin
    snap_view[0] = {sin.eject_request_n,
                    sin.drive_dma_request,
                    sin.drive_io_ready,
                    sin.system_interrupt_input,
                    sin.disk_ready_input,
                    sin.bus_powered_select,
                    sin.bus_power_valid,
                    sin.drive_power_valid};
    snap_view[1] = {pins_q.drive_read_strobe_n,
                    pins_q.drive_write_strobe_n,
                    pins_q.drive_reset_n,
                    pins_q.high_current_request_n,
                    1'b0,
                    pins_q.low_power_indicator,
                    1'b1,
                    sin.drive_interrupt};
    snap_view[2] = {pins_q.drive_reg_address,
                    pins_q.drive_chip_select_n,
                    1'b0,
                    pins_q.drive_pullup_enable,
                    pins_q.drive_dma_ack_n};
    snap_view[3] = sin.drive_data_bus_in[7:0];
    snap_view[4] = sin.drive_data_bus_in[15:8];
    snap_view[5] = {pins_q.gpio_enable,
                    pins_q.data_bus_output_enable,
                    1'b0,
                    sin.gpio_in};
    snap_view[6] = {6'h3F,
                    sin.drive_port_enable,
                    test_mode_q};
    snap_view[7] = 8'hFF;
  end

  // Whole snapshot frozen at setup so every byte shares one instant
  genvar s;
  generate
    for (s = 0; s <= SNAP_LAST; s++)
    begin : g_snap
      always_ff @(posedge sys_clk_i)
      begin
        if (sys_rst_i)
          snap_q[s] <= mfg_test_pkg::SNAP_RESET;
        else if (is_snap && !setup_stall)
          snap_q[s] <= snap_view[s];
      end
    end
  endgenerate

  // Read pointer; index field is not used for the snapshot
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      rd_ptr_q  <= 3'h0;
      rd_left_q <= 4'h0;
    end
    else if (is_snap && !setup_stall)
    begin
      rd_ptr_q  <= 3'h0;
      rd_left_q <= setup_i.length[3:0];
    end
    else if (setup_valid_i)
      rd_left_q <= 4'h0;
    else if (rd_take)
    begin
      rd_ptr_q  <= rd_ptr_q + 3'h1;
      rd_left_q <= rd_left_q - 4'h1;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
    end
    else
    begin
      rd_valid_q <= rd_take;
      if (rd_take)
        rd_data_q <= snap_q[rd_ptr_q];
    end
  end

  assign rd_valid_o = rd_valid_q;
  assign rd_data_o  = rd_data_q;

endmodule : mfg_interconnect_test_port

// [logic/mfg_test_pkg.sv]
/*
  Shared constants and carrier types for the manufacturing interconnect
  test port: request codes, test byte layout, snapshot sizes, pin bundles.
  Assumes a control-request engine that splits each vendor request into a
  setup word and a byte stream.
*/
package mfg_test_pkg;

  // Request identification
  localparam logic [7:0]  LOAD_REQ_TYPE  = 8'h40;
  localparam logic [7:0]  LOAD_REQ_CODE  = 8'h05;
  localparam logic [7:0]  SNAP_REQ_TYPE  = 8'hC0;
  localparam logic [7:0]  SNAP_REQ_CODE  = 8'h06;

  // Value field of the load request
  localparam logic [15:0] MODE_NORMAL    = 16'h0000;
  localparam logic [15:0] MODE_TEST      = 16'h0001;

  // Lengths
  localparam logic [15:0] LOAD_LEN       = 16'h0007;
  localparam logic [15:0] SNAP_MAX_LEN   = 16'h0008;
  localparam int          TEST_BYTES     = 6;
  localparam int          SNAP_BYTES     = 8;

  // Reset values
  localparam logic [7:0]  TEST_RESET     = 8'h00;
  localparam logic [7:0]  SNAP_RESET     = 8'h00;

  // Test register offsets
  localparam logic [2:0]  OFS_CTRL_A     = 3'h0;
  localparam logic [2:0]  OFS_CTRL_B     = 3'h1;
  localparam logic [2:0]  OFS_BUS_LOW    = 3'h2;
  localparam logic [2:0]  OFS_BUS_HIGH   = 3'h3;
  localparam logic [2:0]  OFS_GP_CTRL    = 3'h4;

  // Byte 0 of test data
  localparam int          B0_LOW_POWER   = 0;
  localparam int          B0_HIGH_CUR    = 2;
  localparam int          B0_RESET       = 3;
  localparam int          B0_WRITE       = 4;
  localparam int          B0_READ        = 5;
  localparam int          B0_DMA_ACK     = 6;
  localparam int          B0_PULLUP      = 7;

  // Byte 1 of test data
  localparam int          B1_CS_LSB      = 1;
  localparam int          B1_ADDR_LSB    = 3;
  localparam int          B1_SCLK        = 6;
  localparam int          B1_BUS_EN      = 7;

  // Byte 4 of test data
  localparam int          B4_GP_LSB      = 0;
  localparam int          B4_GP_EN_LSB   = 4;

  typedef struct packed {
    logic [7:0]  req_type;
    logic [7:0]  request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } setup_pkt_t;

  typedef struct packed {
    logic        low_power_indicator;
    logic        high_current_request_n;
    logic        drive_reset_n;
    logic        drive_write_strobe_n;
    logic        drive_read_strobe_n;
    logic        drive_dma_ack_n;
    logic        drive_pullup_enable;
    logic [1:0]  drive_chip_select_n;
    logic [2:0]  drive_reg_address;
    logic        serial_clock;
    logic [15:0] drive_data_bus;
    logic        data_bus_output_enable;
    logic [2:0]  gpio_out;
    logic [2:0]  gpio_enable;
  } out_pins_t;

  typedef struct packed {
    logic        drive_power_valid;
    logic        bus_power_valid;
    logic        bus_powered_select;
    logic        disk_ready_input;
    logic        system_interrupt_input;
    logic        drive_io_ready;
    logic        drive_dma_request;
    logic        eject_request_n;
    logic        drive_interrupt;
    logic        drive_port_enable;
    logic [15:0] drive_data_bus_in;
    logic [2:0]  gpio_in;
  } in_pins_t;

  localparam int          IN_PIN_BITS    = $bits(in_pins_t);

endpackage : mfg_test_pkg

// [logic/pin_input_filter.sv]
/*
  Three-stage input synchroniser with agreement filter for asynchronous pins.
  Assumes every bit is independent and may change at any time.
*/
`timescale 1ns/100ps
module pin_input_filter #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  // Pins
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] pins_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] late_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
      late_q <= '0;
    end
    else
    begin
      meta_q <= pins_i;
      sync_q <= meta_q;
      late_q <= sync_q;
    end
  end

  // Output follows only once the two later stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge sys_clk_i)
      begin
        if (sys_rst_i)
          pins_o[g] <= 1'b0;
        else if (sync_q[g] == late_q[g])
          pins_o[g] <= late_q[g];
      end
    end
  endgenerate

endmodule : pin_input_filter

// [bench/mfg_test_port_assertions.sv]
/*
  Concurrent checks on request decode, mode changes and pin views.
  Assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/100ps
module mfg_test_port_assertions (
  // Clock and reset
  input wire logic                     sys_clk_i,
  input wire logic                     sys_rst_i,
  // Requests
  input wire logic                     setup_valid_i,
  input wire mfg_test_pkg::setup_pkt_t setup_i,
  input wire logic                     rd_req_i,
  input wire logic                     rd_valid_o,
  input wire logic                     claim_o,
  input wire logic                     stall_o,
  input wire logic                     test_mode_o,
  // Pins
  input wire mfg_test_pkg::out_pins_t  norm_pins_i,
  input wire mfg_test_pkg::out_pins_t  pins_o,
  input wire logic                     data_bus_oe_n_o,
  input wire logic [2:0]               gpio_oe_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic is_load;
  logic is_snap;
  assign is_load = setup_valid_i && setup_i.req_type == 8'h40 && setup_i.request == 8'h05;
  assign is_snap = setup_valid_i && setup_i.req_type == 8'hC0 && setup_i.request == 8'h06;

  sequence enter_req;
    is_load && setup_i.value == 16'h0001 && setup_i.length <= 16'h0007;
  endsequence
  sequence refused_load;
    is_load && (setup_i.value > 16'h0001 ||
      (setup_i.value == 16'h0001 && setup_i.length > 16'h0007));
  endsequence

  load_enter_a: assert property (enter_req |-> claim_o && !stall_o ##1 test_mode_o)
    else $error("test mode not entered");
  load_leave_a: assert property (is_load && setup_i.value == 16'h0000
    |-> claim_o ##1 !test_mode_o)
    else $error("test mode not left");
  load_refuse_a: assert property (refused_load
    |-> stall_o ##1 test_mode_o == $past(test_mode_o))
    else $error("bad load not refused");
  snap_claim_a: assert property (is_snap && setup_i.length <= 16'h0008
    |-> claim_o && !stall_o)
    else $error("snapshot not claimed");
  snap_stall_a: assert property (is_snap && setup_i.length > 16'h0008 |-> stall_o)
    else $error("long snapshot not stalled");
  foreign_req_a: assert property (setup_valid_i && !is_load && !is_snap |-> !claim_o)
    else $error("foreign request claimed");
  read_answer_a: assert property (rd_valid_o |-> $past(rd_req_i))
    else $error("read byte without pull");
  oe_polarity_a: assert property (data_bus_oe_n_o == !pins_o.data_bus_output_enable
    && gpio_oe_n_o == ~pins_o.gpio_enable)
    else $error("enable polarity wrong");
  normal_follow_a: assert property (!test_mode_o && !$past(test_mode_o) && !$past(sys_rst_i)
    |-> pins_o == $past(norm_pins_i))
    else $error("normal pins not passed");
endmodule : mfg_test_port_assertions

bind mfg_interconnect_test_port mfg_test_port_assertions i_mfg_test_port_assertions (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .setup_valid_i(setup_valid_i),
  .setup_i(setup_i), .rd_req_i(rd_req_i), .rd_valid_o(rd_valid_o), .claim_o(claim_o),
  .stall_o(stall_o), .test_mode_o(test_mode_o), .norm_pins_i(norm_pins_i), .pins_o(pins_o),
  .data_bus_oe_n_o(data_bus_oe_n_o), .gpio_oe_n_o(gpio_oe_n_o));

// [bench/host_request_model.sv]
/*
  Host-side request engine: setup words, data bytes and read pulls, one at a time.
  Assumes claim and stall answer combinationally in the strobe cycle.
*/
`timescale 1ns/100ps
module host_request_model (
  // Clock
  input  wire logic                sys_clk_i,
  // Toward the port
  output mfg_test_pkg::setup_pkt_t setup_o,
  output logic                     setup_valid_o,
  output logic                     wr_valid_o,
  output logic [7:0]               wr_data_o,
  output logic                     rd_req_o,
  // Answers
  input  wire logic                claim_i,
  input  wire logic                stall_i,
  input  wire logic                rd_valid_i,
  input  wire logic [7:0]          rd_data_i
);
  initial
  begin
    setup_o = '0;
    setup_valid_o = 1'h0;
    wr_valid_o = 1'h0;
    wr_data_o = 8'h00;
    rd_req_o = 1'h0;
  end

  // Released fields inverted so stale values never pass
  task automatic send_setup(input logic [7:0] typ, input logic [7:0] code,
      input logic [15:0] val, input logic [15:0] idx, input logic [15:0] len,
      output logic claim, output logic stall);
    @(posedge sys_clk_i);
    setup_o <= {typ, code, val, idx, len};
    setup_valid_o <= 1'h1;
    @(posedge sys_clk_i);
    claim = claim_i;
    stall = stall_i;
    setup_valid_o <= 1'h0;
    setup_o <= ~setup_o;
  endtask : send_setup

  task automatic send_byte(input logic [7:0] data, output logic stall);
    @(posedge sys_clk_i);
    wr_data_o <= data;
    wr_valid_o <= 1'h1;
    @(posedge sys_clk_i);
    stall = stall_i;
    wr_valid_o <= 1'h0;
    wr_data_o <= ~data;
  endtask : send_byte

  task automatic pull_byte(output logic ok, output logic [7:0] data);
    @(posedge sys_clk_i);
    rd_req_o <= 1'h1;
    @(posedge sys_clk_i);
    rd_req_o <= 1'h0;
    @(posedge sys_clk_i);
    ok = rd_valid_i;
    data = rd_data_i;
  endtask : pull_byte
endmodule : host_request_model

// [bench/mfg_interconnect_test_port_tb.sv]
/*
  Self-checking bench for the test port with the host model on the request side.
  Assumes the checker and host model are compiled first.
*/
`timescale 1ns/100ps
module mfg_interconnect_test_port_tb;
  logic                     sys_clk_i;
  logic                     sys_rst_i;
  mfg_test_pkg::setup_pkt_t setup;
  logic                     setup_valid, wr_valid, rd_req, rd_valid, claim, stall, test_mode;
  logic                     c, s, in_test, dd_oe_n;
  logic [7:0]               wr_data, rd_data;
  logic [2:0]               gp_oe_n;
  mfg_test_pkg::out_pins_t  norm, pins;
  mfg_test_pkg::in_pins_t   raw;
  logic [7:0]               tb_bytes [7];
  int                       miscompares, compares;

  mfg_interconnect_test_port i_mfg_interconnect_test_port (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .setup_valid_i(setup_valid), .setup_i(setup),
    .wr_valid_i(wr_valid), .wr_data_i(wr_data), .rd_req_i(rd_req), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .claim_o(claim), .stall_o(stall), .test_mode_o(test_mode),
    .norm_pins_i(norm), .raw_pins_i(raw), .pins_o(pins), .data_bus_oe_n_o(dd_oe_n),
    .gpio_oe_n_o(gp_oe_n));
  host_request_model i_host_request_model (
    .sys_clk_i(sys_clk_i), .setup_o(setup), .setup_valid_o(setup_valid), .wr_valid_o(wr_valid),
    .wr_data_o(wr_data), .rd_req_o(rd_req), .claim_i(claim), .stall_i(stall),
    .rd_valid_i(rd_valid), .rd_data_i(rd_data));

  initial
  begin
    sys_clk_i = 1'h0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check_word(input logic [35:0] got, input logic [35:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  function automatic mfg_test_pkg::out_pins_t test_view();
    test_view = {tb_bytes[0][0], tb_bytes[0][2], tb_bytes[0][3], tb_bytes[0][4],
      tb_bytes[0][5], tb_bytes[0][6], tb_bytes[0][7], tb_bytes[1][2:1], tb_bytes[1][5:3],
      tb_bytes[1][6], tb_bytes[3], tb_bytes[2], tb_bytes[1][7], tb_bytes[4][2:0],
      tb_bytes[4][6:4]};
  endfunction : test_view

  function automatic logic [7:0] snap_byte(input int n);
    mfg_test_pkg::out_pins_t o;
    o = in_test ? test_view() : norm;
    case (n)
      0: snap_byte = {raw[21], raw[22], raw[23], raw[24], raw[25], raw[26], raw[27], raw[28]};
      1: snap_byte = {o[31], o[32], o[33], o[34], 1'h0, o[35], 1'h1, raw[20]};
      2: snap_byte = {o[26:24], o[28:27], 1'h0, o[29], o[30]};
      3: snap_byte = raw.drive_data_bus_in[7:0];
      4: snap_byte = raw.drive_data_bus_in[15:8];
      5: snap_byte = {o[2:0], o[6], 1'h0, raw.gpio_in};
      6: snap_byte = {6'h3F, raw.drive_port_enable, in_test};
      default: snap_byte = 8'hFF;
    endcase
  endfunction : snap_byte

  // Fixed waits: pins follow one edge after each register write
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic load_test(input logic [15:0] idx, input int n);
    i_host_request_model.send_setup(8'h40, 8'h05, 16'h0001, idx, 16'(n), c, s);
    check_word(36'({c, s}), 36'h2, "load claim");
    for (int i = 0; i < n; i++)
    begin
      i_host_request_model.send_byte(idx + i < 7 ? tb_bytes[idx + i] : 8'h00, s);
      check_word(36'(s), 36'h0, "byte stall");
    end
    in_test = 1'h1;
    settle(2);
    check_word(pins, test_view(), "test view");
    check_word(36'(test_mode), 36'h1, "mode on");
  endtask : load_test

  task automatic t_drive;
    tb_bytes = '{8'hA9, 8'hD5, 8'h3C, 8'hC3, 8'h25, 8'hFF, 8'hEE};
    for (int k = 0; k < 2; k++)
    begin
      load_test(16'h0000, 7);
      check_word(36'({dd_oe_n, gp_oe_n}), k ? 36'hA : 36'h5, "enables");
      foreach (tb_bytes[j]) tb_bytes[j] = ~tb_bytes[j];
    end
    foreach (tb_bytes[j]) tb_bytes[j] = ~tb_bytes[j];
    @(posedge sys_clk_i);
    norm <= ~norm;
    settle(2);
    check_word(pins, test_view(), "normal ignored");
  endtask : t_drive

  task automatic t_refuse;
    tb_bytes[2] = 8'h5A;
    tb_bytes[3] = 8'hA5;
    load_test(16'h0002, 7);
    i_host_request_model.send_setup(8'h40, 8'h05, 16'h0002, 16'h0000, 16'h0000, c, s);
    check_word(36'(s), 36'h1, "bad value");
    i_host_request_model.send_setup(8'h40, 8'h05, 16'h0001, 16'h0000, 16'h0008, c, s);
    check_word(36'(s), 36'h1, "long load");
    i_host_request_model.send_setup(8'hC0, 8'h06, 16'h0000, 16'h0000, 16'h0009, c, s);
    check_word(36'(s), 36'h1, "long snapshot");
    i_host_request_model.send_setup(8'h40, 8'h01, 16'h0000, 16'h0000, 16'h0000, c, s);
    check_word(36'({c, s}), 36'h0, "foreign");
    tb_bytes[0] = 8'h81;
    load_test(16'h0000, 7);
    i_host_request_model.send_byte(8'h7E, s);
    check_word(36'(s), 36'h1, "extra byte");
    settle(2);
    check_word(pins, test_view(), "extra not stored");
  endtask : t_refuse

  task automatic t_snap;
    logic       ok;
    logic [7:0] got;
    logic [7:0] m;
    @(posedge sys_clk_i);
    raw <= ~raw;
    settle(6);
    i_host_request_model.send_setup(8'hC0, 8'h06, 16'h0000, 16'h0000, 16'h0008, c, s);
    check_word(36'({c, s}), 36'h2, "snap claim");
    for (int i = 0; i < 8; i++)
    begin
      i_host_request_model.pull_byte(ok, got);
      m = (i == 1) ? 8'hF7 : (i == 2) ? 8'hFB : 8'hFF;
      check_word(36'({ok, got & m}), 36'({1'h1, snap_byte(i) & m}), "snap");
    end
  endtask : t_snap

  task automatic t_leave;
    i_host_request_model.send_setup(8'h40, 8'h05, 16'h0000, 16'h0000, 16'h0000, c, s);
    in_test = 1'h0;
    settle(2);
    check_word(36'({c, s, test_mode}), 36'h4, "leave");
    check_word(pins, norm, "normal view");
  endtask : t_leave

  task automatic close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    miscompares++;
    close_out();
  end

  initial
  begin
    miscompares = 0;
    compares = 0;
    in_test = 1'h0;
    sys_rst_i = 1'h1;
    norm = 36'hA_5C3C_96E1;
    raw = 29'h1234_5678;
    repeat (4) @(posedge sys_clk_i);
    check_word(36'({test_mode, dd_oe_n, gp_oe_n}), 36'h0F, "reset state");
    sys_rst_i <= 1'h0;
    settle(4);
    check_word(pins, norm, "reset view");
    t_drive();
    t_refuse();
    t_snap();
    t_leave();
    t_snap();
    close_out();
  end
endmodule : mfg_interconnect_test_port_tb
